// [common/urs_consts.vh]
`ifndef URS_CONSTS_VH
`define URS_CONSTS_VH
// Register addresses (3-bit select)
`define URS_A_HOLD 3'h0
`define URS_A_IEN 3'h1
`define URS_A_ISTAT 3'h2
`define URS_A_LCTL 3'h3
`define URS_A_MCTL 3'h4
`define URS_A_LSTAT 3'h5
`define URS_A_MSTAT 3'h6
`define URS_A_SCR 3'h7
// Decode keys and field positions
`define URS_LCTL_MAGIC 8'hBF
`define URS_LCTL_DIV_BIT 7
`define URS_MCTL_LOOP_BIT 4
`define URS_EFN_UNLOCK_BIT 4
`define URS_FCTL_EMS_BIT 6
`define URS_SFN_GPIO_BIT 0
`define URS_MCTL_RTS_BIT 1
`define URS_MCTL_DTR_BIT 0
// Reset values
`define URS_RST_BYTE 8'h00
`define URS_RST_LCTL 8'h1D
// Revision code shown at address 0; the value is arbitrary
`define URS_DEV_REV 8'h5A
`endif

// [core/urs_reg_select.v]
`timescale 1ns/100ps
`include "urs_consts.vh"
module urs_reg_select (
    input wire sys_clk_i,
    input wire reset_n_i,
    input wire [2:0] addr_i,
    input wire [7:0] wdata_i,
    input wire wr_i,
    input wire rd_i,
    output reg [7:0] rdata_o,
    input wire [7:0] rx_byte_i,
    input wire [7:0] int_status_i,
    input wire [7:0] line_status_i,
    input wire [7:0] fifo_level_i,
    input wire tx_shift_i,
    input wire rx_pin_i,
    input wire cts_n_i,
    input wire dsr_n_i,
    input wire cd_n_i,
    input wire ri_n_i,
    output reg rx_shift_o,
    output reg tx_pin_o,
    output reg rts_n_o,
    output reg dtr_n_o,
    output reg [3:0] modem_in_o,
    output reg loopback_o,
    output reg tx_load_o,
    output reg [7:0] tx_data_o,
    output reg rx_pop_o,
    output reg fifo_ctl_stb_o,
    output reg trigger_stb_o,
    output reg [7:0] strobe_data_o,
    output reg [15:0] divisor_o,
    output reg [7:0] divisor_fraction_o,
    output reg [7:0] line_control_o,
    output reg [7:0] interrupt_enable_o,
    output reg [7:0] setup_hysteresis_o,
    output reg [7:0] special_function_o,
    output reg [7:0] enhanced_mode_o,
    output reg [7:0] enhanced_function_o,
    output reg [7:0] feature_control_o,
    output reg [31:0] flow_chars_o,
    output reg [31:0] gpio_ctl_o
);
// ======================================================
// Register map by bank
// Two keys pick the bank: the magic line control value and the
// divisor access bit. Magic wins over divisor
// access, so a magic line control always opens the enhanced bank.
//
// Standard bank, divisor access clear:
//   0  read receive byte, write transmit byte
//   1  interrupt enable
//   2  read interrupt status, write FIFO control
//   3  line control
//   4  modem control
//   5  read line status, write setup/hysteresis
//   6  read modem status, write special function when unlocked
//   7  scratch pad, or enhanced mode select when feature bit 6 set
//
// Divisor bank, divisor access set and not magic:
//   0  divisor low byte, or revision code when divisor is zero
//   1  divisor high byte
//   2  fraction divisor when unlocked, status/FIFO control if locked
//   3..7  as in the standard bank
//
// Enhanced bank, line control magic:
//   0  read FIFO level, write trigger levels
//   1  feature control
//   2  enhanced function
//   3  line control, so software can always leave the bank
//   4..7  flow characters, or GPIO control when GPIO access is set
//
// Flow characters pack as resume one, resume two, pause one, pause
// two in bytes 0..3 of one 32-bit port; the GPIO group packs as
// interrupt enable, tristate, polarity and function select.
//
// Address 7 outside the magic bank reads the FIFO level whenever
// feature bit 6 or GPIO access is set, so a polling driver still
// gets live data rather than a stale scratch byte.
//
// The revision code is only shown while both divisor bytes are
// zero; a nonzero write to either divisor byte hides it again.
//
// Writes with no target reach no register, only strobe data: the host bus
// has no error response, and a stray write must not corrupt state.
// Reads with no target return zero.
//
// Bank keys come from registered outputs, so a write that changes
// line control takes effect from the next access on.
//
// Strobes (transmit load, receive pop, FIFO control, trigger) are
// one-cycle pulses in the cycle after the access; the byte that
// went with them stands on strobe data until the next write.
//
// Loopback:
//   The transmit shifter feeds the receive shifter, the serial
//   output sits at mark and both modem outputs are de-asserted.
//   Modem status then reflects the modem control outputs instead
//   of the pins, so software can test its modem handlers offline.
//   The receive pin is not looked at in loopback; if it is low on
//   exit the receiver sees a break, so the line must idle high.
//
// All steering is registered: every pin output lags its source by
// one clock. That costs a cycle on the serial path but keeps every
// top-level output glitch-free.
// ======================================================
// Bank decode
reg [7:0] modem_control_r;
reg [7:0] scratch_pad_r;
wire magic = (line_control_o == `URS_LCTL_MAGIC);
wire dab = line_control_o[`URS_LCTL_DIV_BIT];
wire unlk = enhanced_function_o[`URS_EFN_UNLOCK_BIT];
wire gpio_acc = special_function_o[`URS_SFN_GPIO_BIT];
wire ems = feature_control_o[`URS_FCTL_EMS_BIT];
wire div_bank = dab && !magic;
wire div_zero = (divisor_o == 16'h0000);
// Upper four addresses of the magic bank: flow chars or GPIO group
wire [31:0] hi_grp = gpio_acc ? gpio_ctl_o : flow_chars_o;
// Status/FIFO control window depends on unlock state
wire stat_ok = unlk ? !dab : !magic;
wire loop = modem_control_r[`URS_MCTL_LOOP_BIT];
// Modem status: loopback feeds modem control back, pins ignored
wire [3:0] msr_lines = loop ? {modem_control_r[3], modem_control_r[2],
    modem_control_r[0], modem_control_r[1]} :
    {~cd_n_i, ~ri_n_i, ~dsr_n_i, ~cts_n_i};
// Pick a byte out of a packed 4-byte group by low address bits
function [7:0] pick4;
    input [31:0] grp;
    input [1:0] idx;
    begin
        pick4 = grp[idx*8 +: 8];
    end
endfunction
// ======================================================
// Read data mux
reg [7:0] rd_nxt;
always @* begin
    rd_nxt = 8'h00;
    case (addr_i)
        `URS_A_HOLD: begin
            if (magic)
                rd_nxt = fifo_level_i;
            else if (!dab)
                rd_nxt = rx_byte_i;
            else if (div_zero)
                rd_nxt = `URS_DEV_REV;
            else
                rd_nxt = divisor_o[7:0];
        end
        `URS_A_IEN: begin
            if (magic)
                rd_nxt = feature_control_o;
            else if (dab)
                rd_nxt = divisor_o[15:8];
            else
                rd_nxt = interrupt_enable_o;
        end
        `URS_A_ISTAT: begin
            if (magic)
                rd_nxt = enhanced_function_o;
            else if (div_bank && unlk)
                rd_nxt = divisor_fraction_o;
            else if (stat_ok)
                rd_nxt = int_status_i;
        end
        `URS_A_LCTL: rd_nxt = line_control_o;
        `URS_A_MCTL: begin
            if (magic)
                rd_nxt = pick4(hi_grp, addr_i[1:0]);
            else
                rd_nxt = modem_control_r;
        end
        `URS_A_LSTAT: begin
            if (magic)
                rd_nxt = pick4(hi_grp, addr_i[1:0]);
            else
                rd_nxt = line_status_i;
        end
        `URS_A_MSTAT: begin
            if (magic)
                rd_nxt = pick4(hi_grp, addr_i[1:0]);
            else
                rd_nxt = {msr_lines, 4'h0};
        end
        `URS_A_SCR: begin
            if (magic)
                rd_nxt = pick4(hi_grp, addr_i[1:0]);
            else if (!ems && !gpio_acc)
                rd_nxt = scratch_pad_r;
            else
                rd_nxt = fifo_level_i;
        end
        default: rd_nxt = 8'h00;
    endcase
end
// ======================================================
// Register writes and access strobes
always @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
        rdata_o <= `URS_RST_BYTE;
        modem_control_r <= `URS_RST_BYTE;
        scratch_pad_r <= `URS_RST_BYTE;
        line_control_o <= `URS_RST_LCTL;
        divisor_o <= 16'h0000;
        divisor_fraction_o <= `URS_RST_BYTE;
        interrupt_enable_o <= `URS_RST_BYTE;
        setup_hysteresis_o <= `URS_RST_BYTE;
        special_function_o <= `URS_RST_BYTE;
        enhanced_mode_o <= `URS_RST_BYTE;
        enhanced_function_o <= `URS_RST_BYTE;
        feature_control_o <= `URS_RST_BYTE;
        flow_chars_o <= 32'h00000000;
        gpio_ctl_o <= 32'h00000000;
        tx_load_o <= 1'b0;
        tx_data_o <= `URS_RST_BYTE;
        rx_pop_o <= 1'b0;
        fifo_ctl_stb_o <= 1'b0;
        trigger_stb_o <= 1'b0;
        strobe_data_o <= `URS_RST_BYTE;
    end else begin
        // Read data stands only in the cycle after the strobe
        rdata_o <= rd_i ? rd_nxt : 8'h00;
        rx_pop_o <= rd_i && addr_i == `URS_A_HOLD && !dab;
        tx_load_o <= 1'b0;
        fifo_ctl_stb_o <= 1'b0;
        trigger_stb_o <= 1'b0;
        if (wr_i) begin
            strobe_data_o <= wdata_i;
            case (addr_i)
                `URS_A_HOLD: begin
                    if (magic)
                        trigger_stb_o <= 1'b1;
                    else if (dab)
                        divisor_o[7:0] <= wdata_i;
                    else begin
                        tx_load_o <= 1'b1;
                        tx_data_o <= wdata_i;
                    end
                end
                `URS_A_IEN: begin
                    if (magic)
                        feature_control_o <= wdata_i;
                    else if (dab)
                        divisor_o[15:8] <= wdata_i;
                    else
                        interrupt_enable_o <= wdata_i;
                end
                `URS_A_ISTAT: begin
                    if (magic)
                        enhanced_function_o <= wdata_i;
                    else if (div_bank && unlk)
                        divisor_fraction_o <= wdata_i;
                    else if (stat_ok)
                        fifo_ctl_stb_o <= 1'b1;
                end
                `URS_A_LCTL: line_control_o <= wdata_i;
                // Magic bank aliases 4..7 onto flow chars or GPIO set
                `URS_A_MCTL: begin
                    if (magic && gpio_acc)
                        gpio_ctl_o[7:0] <= wdata_i;
                    else if (magic)
                        flow_chars_o[7:0] <= wdata_i;
                    else
                        modem_control_r <= wdata_i;
                end
                `URS_A_LSTAT: begin
                    if (magic && gpio_acc)
                        gpio_ctl_o[15:8] <= wdata_i;
                    else if (magic)
                        flow_chars_o[15:8] <= wdata_i;
                    else
                        setup_hysteresis_o <= wdata_i;
                end
                `URS_A_MSTAT: begin
                    if (magic && gpio_acc)
                        gpio_ctl_o[23:16] <= wdata_i;
                    else if (magic)
                        flow_chars_o[23:16] <= wdata_i;
                    else if (unlk)
                        special_function_o <= wdata_i;
                end
                `URS_A_SCR: begin
                    if (magic && gpio_acc)
                        gpio_ctl_o[31:24] <= wdata_i;
                    else if (magic)
                        flow_chars_o[31:24] <= wdata_i;
                    else if (!gpio_acc) begin
                        if (ems)
                            enhanced_mode_o <= wdata_i;
                        else
                            scratch_pad_r <= wdata_i;
                    end
                end
                default: begin
                end
            endcase
        end
    end
end
// ======================================================
// Loopback pin steering; the core keeps running either way
always @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
        rx_shift_o <= 1'b1;
        tx_pin_o <= 1'b1;
        rts_n_o <= 1'b1;
        dtr_n_o <= 1'b1;
        modem_in_o <= 4'h0;
        loopback_o <= 1'b0;
    end else begin
        loopback_o <= loop;
        // Receive pin is not looked at in loopback; a low pin there
        // shows up as a break once loopback is left.
        rx_shift_o <= loop ? tx_shift_i : rx_pin_i;
        tx_pin_o <= loop ? 1'b1 : tx_shift_i;
        rts_n_o <= loop ? 1'b1 :
            ~modem_control_r[`URS_MCTL_RTS_BIT];
        dtr_n_o <= loop ? 1'b1 :
            ~modem_control_r[`URS_MCTL_DTR_BIT];
        modem_in_o <= msr_lines;
    end
end
endmodule

// [dv/urs_reg_select_sva.sv]
`timescale 1ns/100ps
`include "urs_consts.vh"
// ====================
// Decode and loopback checker
module urs_chk (
    input wire sys_clk_i,
    input wire reset_n_i,
    input wire [2:0] addr_i,
    input wire [7:0] wdata_i,
    input wire wr_i,
    input wire rd_i,
    input wire [7:0] rdata_o,
    input wire [7:0] rx_byte_i,
    input wire tx_shift_i,
    input wire rx_pin_i,
    input wire rx_shift_o,
    input wire tx_pin_o,
    input wire rts_n_o,
    input wire dtr_n_o,
    input wire [3:0] modem_in_o,
    input wire loopback_o,
    input wire tx_load_o,
    input wire [7:0] tx_data_o,
    input wire rx_pop_o,
    input wire [15:0] divisor_o,
    input wire [7:0] line_control_o,
    input wire [7:0] feature_control_o
);
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!reset_n_i);
    // Bank keys seen by every decode check but the line control write
    wire magic = line_control_o == `URS_LCTL_MAGIC;
    wire dacc = line_control_o[`URS_LCTL_DIV_BIT];
    // Two cycles in loop covers either output lag
    sequence s_loop_held;
        loopback_o && $past(loopback_o) && $past(reset_n_i);
    endsequence
    sequence s_thr_wr;
        wr_i && addr_i == `URS_A_HOLD && !dacc;
    endsequence
    a_loop_enter: assert property (wr_i && addr_i == `URS_A_MCTL && !magic
        |-> ##2 loopback_o == $past(wdata_i[4], 2))
        else $error("loop bit");
    a_loop_pins: assert property (s_loop_held
        |-> tx_pin_o && rts_n_o && dtr_n_o) else $error("loop pins");
    a_loop_route: assert property (s_loop_held
        |-> rx_shift_o == $past(tx_shift_i)) else $error("loop route");
    a_norm_route: assert property (!loopback_o && !$past(loopback_o)
        && $past(reset_n_i) |-> rx_shift_o == $past(rx_pin_i))
        else $error("normal route");
    a_modem_hold: assert property (s_loop_held and (!$past(wr_i)
        && !$past(wr_i, 2)) |-> $stable(modem_in_o))
        else $error("modem pins leak");
    a_thr_load: assert property (s_thr_wr
        |=> tx_load_o && tx_data_o == $past(wdata_i)) else $error("thr");
    a_rx_pop: assert property (rd_i && addr_i == `URS_A_HOLD && !dacc
        |=> rx_pop_o && rdata_o == $past(rx_byte_i)) else $error("rhr");
    a_lctl_write: assert property (wr_i && addr_i == `URS_A_LCTL
        |=> line_control_o == $past(wdata_i)) else $error("lctl");
    a_div_low: assert property (wr_i && addr_i == `URS_A_HOLD && dacc
        && !magic |=> divisor_o[7:0] == $past(wdata_i)) else $error("dll");
    a_fctl_magic: assert property (wr_i && addr_i == `URS_A_IEN && magic
        |=> feature_control_o == $past(wdata_i)) else $error("feature_control");
endmodule
bind urs_reg_select urs_chk u_chk (.sys_clk_i, .reset_n_i, .addr_i,
    .wdata_i, .wr_i, .rd_i, .rdata_o, .rx_byte_i, .tx_shift_i, .rx_pin_i,
    .rx_shift_o, .tx_pin_o, .rts_n_o, .dtr_n_o, .modem_in_o, .loopback_o,
    .tx_load_o, .tx_data_o, .rx_pop_o, .divisor_o, .line_control_o,
    .feature_control_o);

// [dv/urs_reg_select_tb_top.sv]
`timescale 1ns/100ps
`include "urs_consts.vh"
module urs_reg_select_tb_top;
    reg sys_clk_i = 0;
    reg reset_n_i = 0;
    reg [2:0] addr_i = 0;
    reg [7:0] wdata_i = 0;
    reg wr_i = 0, rd_i = 0, in_loop = 0;
    reg [7:0] rx_byte_i = 0, int_status_i = 0, line_status_i = 0;
    reg [7:0] fifo_level_i = 0, d;
    reg tx_shift_i = 1, rx_pin_i = 1, cts_n_i = 1, dsr_n_i = 1;
    reg cd_n_i = 1, ri_n_i = 1;
    reg [31:0] fc, gc;
    reg [2:0] a;
    integer failures = 0, tests_run = 0;
    // Reference model of the register map, kept from the rules alone
    int m_lc = `URS_RST_LCTL, m_dl = 0, m_dm = 0, m_ie = 0, m_sp = 0;
    int m_fc = 0, m_ef = 0, m_sf = 0, m_mc = 0, m_dd = 0;
    int m_xo[4], m_gp[4];
    int exp_q[$];
    wire [7:0] rdata_o, tx_data_o, strobe_data_o, divisor_fraction_o;
    wire [7:0] line_control_o, interrupt_enable_o, setup_hysteresis_o;
    wire [7:0] special_function_o, enhanced_mode_o, enhanced_function_o;
    wire [7:0] feature_control_o;
    wire [15:0] divisor_o;
    wire [31:0] flow_chars_o, gpio_ctl_o;
    wire [3:0] modem_in_o;
    wire rx_shift_o, tx_pin_o, rts_n_o, dtr_n_o, loopback_o, tx_load_o;
    wire rx_pop_o, fifo_ctl_stb_o, trigger_stb_o;
    urs_reg_select uut (.sys_clk_i, .reset_n_i, .addr_i, .wdata_i, .wr_i,
        .rd_i, .rdata_o, .rx_byte_i, .int_status_i, .line_status_i,
        .fifo_level_i, .tx_shift_i, .rx_pin_i, .cts_n_i, .dsr_n_i, .cd_n_i,
        .ri_n_i, .rx_shift_o, .tx_pin_o, .rts_n_o, .dtr_n_o, .modem_in_o,
        .loopback_o, .tx_load_o, .tx_data_o, .rx_pop_o, .fifo_ctl_stb_o,
        .trigger_stb_o, .strobe_data_o, .divisor_o, .divisor_fraction_o,
        .line_control_o, .interrupt_enable_o, .setup_hysteresis_o,
        .special_function_o, .enhanced_mode_o, .enhanced_function_o,
        .feature_control_o, .flow_chars_o, .gpio_ctl_o);
    always #25 sys_clk_i = ~sys_clk_i;
    // Serial and modem pins churn; receive pin parks high in loop test
    always @(posedge sys_clk_i) begin
        {tx_shift_i, cts_n_i, dsr_n_i, cd_n_i, ri_n_i, rx_pin_i} <=
            6'($urandom) | {5'h00, in_loop};
    end
    task chk(input string n, input [31:0] s, input [31:0] e);
        tests_run = tests_run + 1;
        if (s !== e) begin
            failures = failures + 1;
            $display("MISMATCH %s exp %h seen %h", n, e, s);
        end
    endtask
    // Model read: what the map should return for this address now
    function automatic int m_rd(input [2:0] ad);
        bit mg, dv, un;
        int hi;
        mg = m_lc == `URS_LCTL_MAGIC;
        dv = m_lc[`URS_LCTL_DIV_BIT];
        un = m_ef[`URS_EFN_UNLOCK_BIT];
        hi = m_sf[0] ? m_gp[ad[1:0]] : m_xo[ad[1:0]];
        m_rd = 0;
        case (ad)
            0: m_rd = mg ? fifo_level_i : !dv ? rx_byte_i :
                (m_dl == 0 && m_dm == 0) ? `URS_DEV_REV : m_dl;
            1: m_rd = mg ? m_fc : dv ? m_dm : m_ie;
            2: m_rd = mg ? m_ef : (dv && un) ? m_dd :
                (un ? !dv : 1) ? int_status_i : 0;
            3: m_rd = m_lc;
            4: m_rd = mg ? hi : m_mc;
            5: m_rd = mg ? hi : line_status_i;
            6: m_rd = mg ? hi : m_mc[4] ?
                {m_mc[3], m_mc[2], m_mc[0], m_mc[1], 4'h0} :
                {~cd_n_i, ~ri_n_i, ~dsr_n_i, ~cts_n_i, 4'h0};
            default: m_rd = mg ? hi :
                (m_fc[6] || m_sf[0]) ? fifo_level_i : m_sp;
        endcase
    endfunction
    // Model write: update the shadow registers a write would reach
    task automatic m_wr(input [2:0] ad, input [7:0] dt);
        bit mg, dv;
        mg = m_lc == `URS_LCTL_MAGIC;
        dv = m_lc[`URS_LCTL_DIV_BIT];
        if (mg && ad > 3) begin
            if (m_sf[0])
                m_gp[ad[1:0]] = dt;
            else
                m_xo[ad[1:0]] = dt;
        end else if (ad == 0 && dv && !mg) begin
            m_dl = dt;
        end else if (ad == 1) begin
            if (mg)
                m_fc = dt;
            else if (dv)
                m_dm = dt;
            else
                m_ie = dt;
        end else if (ad == 2) begin
            if (mg)
                m_ef = dt;
            else if (dv && m_ef[4])
                m_dd = dt;
        end else if (ad == 3) begin
            m_lc = dt;
        end else if (ad == 4) begin
            m_mc = dt;
        end else if (ad == 6 && m_ef[4]) begin
            m_sf = dt;
        end else if (ad == 7 && !m_sf[0] && !m_fc[6]) begin
            m_sp = dt;
        end
    endtask
    // One-cycle strobes; outputs are sampled just after the taking edge
    task wr(input [2:0] ad, input [7:0] dt);
        @(posedge sys_clk_i);
        addr_i <= ad;
        wdata_i <= dt;
        wr_i <= 1'b1;
        @(posedge sys_clk_i);
        wr_i <= 1'b0;
        #1;
        m_wr(ad, dt);
    endtask
    task rd(input [2:0] ad, input [7:0] e, input string n);
        @(posedge sys_clk_i);
        addr_i <= ad;
        rd_i <= 1'b1;
        exp_q.push_back(m_rd(ad));
        @(posedge sys_clk_i);
        rd_i <= 1'b0;
        #1;
        chk(n, rdata_o, e);
        chk({n, " model"}, rdata_o, exp_q.pop_front());
    endtask
    task final_report;
        $display("checks %0d failures %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    // Hang guard, far beyond the roughly 140 cycles needed
    initial begin
        #250000;
        failures = failures + 1;
        final_report;
    end
    initial begin
        fc = $urandom(32'hEF68);
        {rx_byte_i, int_status_i, line_status_i, fifo_level_i} = $urandom;
        d = $urandom;
        repeat (12) @(posedge sys_clk_i);
        reset_n_i <= 1'b1;
        rd(`URS_A_LCTL, `URS_RST_LCTL, "lctl");
        rd(0, rx_byte_i, "rhr");
        rd(2, int_status_i, "isr");
        rd(5, line_status_i, "lsr");
        wr(0, d);
        chk("thr", {tx_load_o, tx_data_o}, {1'b1, d});
        wr(1, d);
        rd(1, d, "ier");
        wr(7, ~d);
        rd(7, ~d, "spr");
        wr(5, d);
        chk("shr", setup_hysteresis_o, d);
        wr(6, d);
        chk("sfr locked", special_function_o, 0);
        wr(3, 8'h80);
        rd(0, `URS_DEV_REV, "rev");
        wr(2, d);
        chk("fcr", {fifo_ctl_stb_o, divisor_fraction_o}, 9'h100);
        wr(0, d);
        wr(1, ~d);
        chk("div", divisor_o, {~d, d});
        rd(1, ~d, "dlm");
        wr(3, `URS_LCTL_MAGIC);
        rd(0, fifo_level_i, "fc");
        wr(0, d);
        chk("trg", {trigger_stb_o, strobe_data_o}, {1'b1, d});
        wr(2, 8'h10);
        rd(2, 8'h10, "efr");
        wr(1, 8'h40);
        rd(1, 8'h40, "feature_control");
        for (a = 4; a != 0; a = a + 1) wr(a, fc[8*a[1:0]+:8]);
        chk("flow", flow_chars_o, fc);
        for (a = 4; a != 0; a = a + 1) rd(a, fc[8*a[1:0]+:8], "xo");
        wr(3, 8'h80);
        wr(2, d);
        chk("dld", divisor_fraction_o, d);
        wr(3, 8'h03);
        rd(2, int_status_i, "isr unl");
        wr(7, d);
        chk("enhanced_mode_select", enhanced_mode_o, d);
        wr(6, 8'h01);
        chk("sfr", special_function_o, 8'h01);
        wr(3, `URS_LCTL_MAGIC);
        gc = ~fc;
        for (a = 4; a != 0; a = a + 1) wr(a, gc[8*a[1:0]+:8]);
        chk("gpio", {gpio_ctl_o, flow_chars_o}, {gc, fc});
        wr(3, 8'h03);
        in_loop = 1'b1;
        wr(4, 8'h13);
        repeat (3) @(posedge sys_clk_i);
        #1;
        chk("loop", {loopback_o, tx_pin_o, rts_n_o, dtr_n_o, modem_in_o},
            8'hF3);
        rd(6, 8'h30, "msr loop");
        repeat (20) @(posedge sys_clk_i);
        wr(4, 8'h03);
        repeat (2) @(posedge sys_clk_i);
        #1;
        in_loop = 1'b0;
        chk("unloop", {loopback_o, rts_n_o, dtr_n_o}, 3'b000);
        repeat (10) @(posedge sys_clk_i);
        final_report;
    end
endmodule
